/* design/tps_pkg.sv */
/*
  Constants for the three-rail power sequencer: sequencing clock rate,
  step counts and state encoding.
  Assumes a 100 MHz core clock.
*/
package tps_pkg;

  // Core clock period
  localparam int CORE_CLK_NS    = 10;
  // Sequencing clock period per nF of timing capacitor
  localparam int SEQ_US_PER_NF  = 120;
  // Default timing capacitor value
  localparam int TIMING_CAP_NF  = 10;
  // Core cycles per sequencing clock period
  localparam int SEQ_TICK_CYCLES = (SEQ_US_PER_NF * 1000 * TIMING_CAP_NF) / CORE_CLK_NS;

  // Sequencing clock periods per step
  localparam logic [3:0] FIRST_TICKS = 4'ha;
  localparam logic [3:0] STEP_TICKS  = 4'h8;

  // Number of rails and the released level after reset
  localparam logic [1:0] LEVEL_NONE = 2'h0;
  localparam logic [1:0] LEVEL_ALL  = 2'h3;

  typedef enum logic [1:0] {
    TPS_IDLE,
    TPS_UP,
    TPS_HOLD,
    TPS_DOWN
  } tps_state_t;

endpackage : tps_pkg

/* design/tps_sequencer.sv */
/*
  Three-rail power sequencer: releases three open-drain rail outputs in
  order 1-2-3 after the sequence request rises, withdraws them 3-2-1 when
  it falls. Timing comes from a divided sequencing clock.
  Assumes inputs synchronous to core_clk and external pull-ups on the rails.
*/
// What this block does
// - Sequencing clock period set by timing capacitor
// - All rails inactive until request rises
// - Rail 1 released after nine to ten periods
// - Rail 2 released eight periods after rail 1
// - Rail 3 released eight periods after rail 2
// - On request fall, withdraw 3, 2, 1
// - Request drop before rail 1 resets count
// - Drop mid power-up gives controlled shutdown
// - Polarity low: rails active high
// - Polarity high: rails active low
// - Rails are open-drain pull-downs only
`timescale 1ns/1ps

module tps_sequencer #(
  parameter int TICK_CYCLES = tps_pkg::SEQ_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic seq_request,
  input  wire logic polarity_select,
  // Timing waveform, high while charging
  output logic      timing_cap_pin,
  // Rail 1 open-drain pin
  input  wire logic rail_release_1_i,
  output logic      rail_release_1_o,
  output logic      rail_release_1_oe,
  // Rail 2 open-drain pin
  input  wire logic rail_release_2_i,
  output logic      rail_release_2_o,
  output logic      rail_release_2_oe,
  // Rail 3 open-drain pin
  input  wire logic rail_release_3_i,
  output logic      rail_release_3_o,
  output logic      rail_release_3_oe
);

  localparam int PW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing clock

  logic [PW-1:0] prescale;
  logic          tick;
  wire  logic    prescale_end = (prescale == PW'(TICK_CYCLES - 1));
  wire  logic    next_phase   = (prescale < PW'(TICK_CYCLES / 2));

  // Free-running, so the first tick after a request lands anywhere in a period
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prescale       <= '0;
      tick           <= 1'b0;
      timing_cap_pin <= 1'b0;
    end else begin
      prescale       <= prescale_end ? '0 : prescale + 1'b1;
      tick           <= prescale_end;
      timing_cap_pin <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  tps_pkg::tps_state_t state;
  tps_pkg::tps_state_t next_state;
  logic [1:0]          level;
  logic [1:0]          next_level;
  logic [3:0]          tcnt;
  logic [3:0]          next_tcnt;
  logic                first;
  logic                next_first;

  // First step of either direction is the long one
  wire logic [3:0] step_target = first ? tps_pkg::FIRST_TICKS : tps_pkg::STEP_TICKS;
  wire logic       step_done   = tick && (tcnt + 4'h1 == step_target);

  always_comb begin
    next_state = state;
    next_level = level;
    next_tcnt  = tcnt;
    next_first = first;
    case (state)
      tps_pkg::TPS_IDLE: begin
        next_level = tps_pkg::LEVEL_NONE;
        if (seq_request) begin
          next_state = tps_pkg::TPS_UP;
          next_tcnt  = 4'h0;
          next_first = 1'b1;
        end
      end
      tps_pkg::TPS_UP: begin
        if (!seq_request && level == tps_pkg::LEVEL_NONE) begin
          next_state = tps_pkg::TPS_IDLE;
          next_tcnt  = 4'h0;
        end else if (!seq_request) begin
          next_state = tps_pkg::TPS_DOWN;
          next_tcnt  = 4'h0;
          next_first = 1'b1;
        end else if (step_done) begin
          next_level = level + 2'h1;
          next_tcnt  = 4'h0;
          next_first = 1'b0;
          if (level + 2'h1 == tps_pkg::LEVEL_ALL) begin
            next_state = tps_pkg::TPS_HOLD;
          end
        end else if (tick) begin
          next_tcnt = tcnt + 4'h1;
        end
      end
      tps_pkg::TPS_HOLD: begin
        if (!seq_request) begin
          next_state = tps_pkg::TPS_DOWN;
          next_tcnt  = 4'h0;
          next_first = 1'b1;
        end
      end
      tps_pkg::TPS_DOWN: begin
        // Shutdown always runs to the end; a new request waits for idle
        if (step_done) begin
          next_level = level - 2'h1;
          next_tcnt  = 4'h0;
          next_first = 1'b0;
          if (level == 2'h1) begin
            next_state = tps_pkg::TPS_IDLE;
          end
        end else if (tick) begin
          next_tcnt = tcnt + 4'h1;
        end
      end
      default: begin
        next_state = tps_pkg::TPS_IDLE;
        next_level = tps_pkg::LEVEL_NONE;
        next_tcnt  = 4'h0;
        next_first = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= tps_pkg::TPS_IDLE;
      level <= tps_pkg::LEVEL_NONE;
      tcnt  <= 4'h0;
      first <= 1'b0;
    end else begin
      state <= next_state;
      level <= next_level;
      tcnt  <= next_tcnt;
      first <= next_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain rail pins

  // Pull low when the pin level must be low: inactive without inversion, or active with inversion
  wire logic next_oe_1 = ~((next_level >= 2'h1) ^ polarity_select);
  wire logic next_oe_2 = ~((next_level >= 2'h2) ^ polarity_select);
  wire logic next_oe_3 = ~((next_level >= 2'h3) ^ polarity_select);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rail_release_1_oe <= ~polarity_select;
      rail_release_2_oe <= ~polarity_select;
      rail_release_3_oe <= ~polarity_select;
    end else begin
      rail_release_1_oe <= next_oe_1;
      rail_release_2_oe <= next_oe_2;
      rail_release_3_oe <= next_oe_3;
    end
  end

  // Never drive high; the pull-ups make the released level
  always_ff @(posedge core_clk) begin
    rail_release_1_o <= 1'b0;
    rail_release_2_o <= 1'b0;
    rail_release_3_o <= 1'b0;
  end

  // Pin readbacks are not needed by the sequencer itself
  wire logic unused_pins = rail_release_1_i ^ rail_release_2_i ^ rail_release_3_i;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Ticks seen since the last change of level or state
  logic [3:0] h_ticks;
  always_ff @(posedge core_clk) begin
    if (!rst_n || next_level != level || next_state != state) begin
      h_ticks <= 4'h0;
    end else if (tick) begin
      h_ticks <= h_ticks + 4'h1;
    end
  end

  a_first_release_delay: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_UP && level == 2'h0 && next_level == 2'h1) |-> h_ticks == 4'h9
  ) else $error("rail 1 released after wrong tick count");

  a_rail_two_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (level == 2'h1 && next_level == 2'h2) |-> h_ticks == 4'h7
  ) else $error("rail 2 released after wrong tick count");

  a_rail_three_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (level == 2'h2 && next_level == 2'h3) |-> h_ticks == 4'h7
  ) else $error("rail 3 released after wrong tick count");

  a_down_first_delay: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_DOWN && first && next_level < level) |-> h_ticks == 4'h9
  ) else $error("first withdrawal after wrong tick count");

  a_down_step_delay: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_DOWN && !first && next_level < level) |-> h_ticks == 4'h7
  ) else $error("later withdrawal after wrong tick count");

  a_glitch_cancel: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_UP && level == 2'h0 && !seq_request)
      |=> (state == tps_pkg::TPS_IDLE && level == 2'h0)
  ) else $error("early request drop did not cancel");

  a_partial_shutdown: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_UP && level != 2'h0 && !seq_request)
      |=> (state == tps_pkg::TPS_DOWN && level == $past(level))
  ) else $error("mid power-up drop did not start shutdown");

  a_idle_all_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state == tps_pkg::TPS_IDLE |-> level == 2'h0
  ) else $error("rail released while idle");

  a_rail_one_sense: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ##1 rail_release_1_oe == ~((level >= 2'h1) ^ $past(polarity_select))
  ) else $error("rail 1 pin sense wrong");

  a_rail_three_sense: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ##1 rail_release_3_oe == ~((level == 2'h3) ^ $past(polarity_select))
  ) else $error("rail 3 pin sense wrong");

  a_rail_two_sense: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ##1 rail_release_2_oe == ~((level >= 2'h2) ^ $past(polarity_select))
  ) else $error("rail 2 pin sense wrong");

  a_drain_never_high: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !rail_release_1_o && !rail_release_2_o && !rail_release_3_o
  ) else $error("rail pin driven high");

  a_up_one_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_UP && next_level != level) |-> next_level == level + 2'h1
  ) else $error("power-up skipped a rail");

  a_down_one_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_DOWN && next_level != level) |-> next_level == level - 2'h1
  ) else $error("shutdown skipped a rail");

  a_hold_all_on: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state == tps_pkg::TPS_HOLD |-> level == tps_pkg::LEVEL_ALL
  ) else $error("hold reached without all rails");

  a_request_starts_count: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == tps_pkg::TPS_IDLE && seq_request)
      |=> (state == tps_pkg::TPS_UP && tcnt == 4'h0 && first)
  ) else $error("request did not start a fresh count");

  // Cycles since the last tick; starts at all ones so the first
  // period counts from the release of reset, as the prescaler does
  logic [PW-1:0] h_gap;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      h_gap <= '1;
    end else if (tick) begin
      h_gap <= '0;
    end else begin
      h_gap <= h_gap + 1'b1;
    end
  end

  a_tick_spacing: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tick |-> h_gap == PW'(TICK_CYCLES - 1)
  ) else $error("sequencing tick spacing wrong");

endmodule : tps_sequencer

/* test/tps_reg_model.sv */
/*
  Enable inputs of three regulators on the rail pins, with pull-ups.
  Assumes the sequencer pulls a pin low while its enable is high.
*/
`timescale 1ns/1ps

module tps_reg_model (
  // Pull-down enables from the sequencer
  input  wire logic [2:0] pull_low,
  input  wire logic       active_low,
  // Resolved pin levels and regulator state
  output logic      [2:0] pin,
  output logic      [2:0] reg_on
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pull-up wins whenever the open drain lets go
  assign pin    = ~pull_low;
  assign reg_on = active_low ? ~pin : pin;
endmodule : tps_reg_model

/* test/tps_sequencer_tb_top.sv */
/*
  Self-checking bench for the three-rail power sequencer.
  Assumes a short sequencing period set through TICK_CYCLES.
*/
`timescale 1ns/1ps

module tps_sequencer_tb_top;
  localparam int T = 4;
  logic       core_clk;
  logic       rst_n;
  logic       seq_request;
  logic       polarity_select;
  logic       timing_cap_pin;
  logic [2:0] rail_o;
  logic [2:0] rail_oe;
  logic [2:0] pin;
  logic [2:0] reg_on;
  logic [2:0] hi_seen;
  int         errors;
  int         checks_done;

  tps_sequencer #(.TICK_CYCLES(T)) tps_sequencer_i (
    .core_clk(core_clk), .rst_n(rst_n), .seq_request(seq_request),
    .polarity_select(polarity_select), .timing_cap_pin(timing_cap_pin),
    .rail_release_1_i(pin[0]), .rail_release_1_o(rail_o[0]), .rail_release_1_oe(rail_oe[0]),
    .rail_release_2_i(pin[1]), .rail_release_2_o(rail_o[1]), .rail_release_2_oe(rail_oe[1]),
    .rail_release_3_i(pin[2]), .rail_release_3_o(rail_o[2]), .rail_release_3_oe(rail_oe[2])
  );

  tps_reg_model tps_reg_model_i (
    .pull_low(rail_oe), .active_low(polarity_select), .pin(pin), .reg_on(reg_on)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Rails that ever left their inactive level since the last reset
  always @(posedge core_clk) begin
    if (!rst_n) begin
      hi_seen <= 3'h0;
    end else begin
      hi_seen <= hi_seen | (pin ^ {3{polarity_select}});
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic wait_rail(input int k, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 40 * T) begin
        errors++;
        test_done();
      end
    end while (pin[k] !== lvl);
  endtask : wait_rail

  task automatic set_req(input logic v);
    @(negedge core_clk);
    seq_request = v;
  endtask : set_req

  // Polarity only moves under reset, as it must be static
  task automatic do_reset(input logic pol);
    @(negedge core_clk);
    rst_n = 1'b0;
    seq_request = 1'b0;
    polarity_select = pol;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  task automatic full_cycle(input logic pol);
    int   n;
    logic on;
    on = ~pol;
    do_reset(pol);
    repeat (5 * T) @(negedge core_clk);
    check(pin, {3{pol}});
    set_req(1'b1);
    wait_rail(0, on, n);
    check(n >= 9 * T && n <= 10 * T + 2, 1);
    check(pin[2:1], {2{pol}});
    wait_rail(1, on, n);
    check(n, 8 * T);
    check(pin[2], pol);
    wait_rail(2, on, n);
    check(n, 8 * T);
    check(reg_on, 3'h7);
    set_req(1'b0);
    wait_rail(2, pol, n);
    check(n >= 9 * T && n <= 10 * T + 2, 1);
    check(pin[1:0], {2{on}});
    wait_rail(1, pol, n);
    check(n, 8 * T);
    wait_rail(0, pol, n);
    check(n, 8 * T);
    check(rail_o, 3'h0);
  endtask : full_cycle

  // A short drop must restart the first count from the new rise
  task automatic glitch();
    int n;
    do_reset(1'b0);
    set_req(1'b1);
    repeat (6 * T) @(negedge core_clk);
    seq_request = 1'b0;
    repeat (2) @(negedge core_clk);
    check(hi_seen, 3'h0);
    seq_request = 1'b1;
    wait_rail(0, 1'b1, n);
    check(n >= 9 * T && n <= 10 * T + 2, 1);
    set_req(1'b0);
    wait_rail(0, 1'b0, n);
  endtask : glitch

  task automatic partial();
    int n;
    do_reset(1'b0);
    set_req(1'b1);
    wait_rail(0, 1'b1, n);
    set_req(1'b0);
    wait_rail(0, 1'b0, n);
    check(n >= 9 * T && n <= 10 * T + 2, 1);
    check(hi_seen, 3'h1);
  endtask : partial

  // Sequencing waveform: period T, high for half of it
  task automatic cap_wave();
    int   hi;
    int   rises;
    logic prev;
    hi = 0;
    rises = 0;
    do_reset(1'b0);
    @(posedge core_clk);
    #1;
    prev = timing_cap_pin;
    repeat (4 * T) begin
      @(posedge core_clk);
      #1;
      hi += (timing_cap_pin === 1'b1);
      rises += (timing_cap_pin === 1'b1 && prev === 1'b0);
      prev = timing_cap_pin;
    end
    check(hi, 4 * (T / 2));
    check(rises, 4);
  endtask : cap_wave

  initial begin
    rst_n = 1'b0;
    seq_request = 1'b0;
    polarity_select = 1'b0;
    errors = 0;
    checks_done = 0;
    cap_wave();
    full_cycle(1'b0);
    full_cycle(1'b1);
    glitch();
    partial();
    test_done();
  end
endmodule : tps_sequencer_tb_top
